// [verilog/amp_adc_front_end_control.sv]
// Register file and analog control decode of the amplifier and converter front end.
//
// Local design decision: the address-and-strobe port.
module amp_adc_front_end_control
    import front_end_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic [15:0] raw_result,
    output logic amp_enable,
    output logic [2:0] gain_code,
    output logic gain_unity,
    output logic [3:0] gain_shift,
    output logic [1:0] chopper_freq_field,
    output logic [2:0] input_route_code,
    output logic [5:0] amp_in_pos_sel,
    output logic [5:0] amp_in_neg_sel,
    output logic amp_pos_to_common,
    output logic amp_neg_to_common,
    output logic amp_clk,
    output logic amp_clk_tick,
    output logic converter_enable,
    output logic [1:0] reference_code,
    output logic ref_internal,
    output logic inputs_supply_taps,
    output logic converter_path_on,
    output logic converter_clk,
    output logic converter_clk_tick,
    output logic signed [15:0] conversion_result,
    output logic result_sign_bit
);
    logic [7:0] amp_mode;
    logic [7:0] amp_channel_select;
    logic [7:0] amp_clock_divider;
    logic [7:0] converter_mode;
    logic [7:0] converter_clock_divider;

    wire sel_amp_mode = (addr == AMP_MODE_ADDR);
    wire sel_amp_chan = (addr == AMP_CHANNEL_SELECT_ADDR);
    wire sel_amp_div = (addr == AMP_CLOCK_DIVIDER_ADDR);
    wire sel_conv_mode = (addr == CONVERTER_MODE_ADDR);
    wire sel_conv_div = (addr == CONVERTER_CLOCK_DIVIDER_ADDR);

    // Divider registers are write-only and read back as zero, like unmapped addresses.
    wire [7:0] read_mux = sel_amp_mode ? {2'b00, amp_mode[5:0]} :
                          sel_amp_chan ? {5'b00000, amp_channel_select[2:0]} :
                          sel_conv_mode ? {5'b00000, converter_mode[2:0]} : 8'h00;

    wire [2:0] gain_field = amp_mode[GAIN_CODE_LSB +: 3];
    wire [1:0] ref_field = converter_mode[REFERENCE_CODE_LSB +: 2];
    wire [2:0] route_field = amp_channel_select[2:0];
    wire amp_en_bit = amp_mode[AMP_ENABLE_BIT];
    wire conv_en_bit = converter_mode[CONVERTER_ENABLE_BIT];

    // Reserved gain codes keep the amplifier off so the analog path stays at rest.
    logic gain_valid;
    logic [3:0] next_gain_shift;
    always_comb begin
        gain_valid = 1'b1;
        next_gain_shift = 4'h0;
        unique case (gain_field)
            GAIN_16: next_gain_shift = 4'h4; // RQ2
            GAIN_32: next_gain_shift = 4'h5; // RQ2
            GAIN_64: next_gain_shift = 4'h6; // RQ2
            GAIN_128: next_gain_shift = 4'h7; // RQ2
            GAIN_UNITY: next_gain_shift = 4'h0; // RQ2
            default: gain_valid = 1'b0; // RQ17
        endcase
    end

    // One-hot switch selects: bits 0..5 are pair1+, pair1-, pair2+, pair2-, pair3+, pair3-.
    logic [5:0] next_pos_sel;
    logic [5:0] next_neg_sel;
    logic next_pos_common;
    logic next_neg_common;
    always_comb begin
        next_pos_sel = 6'h00;
        next_neg_sel = 6'h00;
        next_pos_common = 1'b0;
        next_neg_common = 1'b0;
        unique case (route_field)
            3'h0: begin
                next_pos_sel = 6'h01; // RQ6
                next_neg_sel = 6'h02; // RQ6
            end
            3'h1: begin
                next_pos_sel = 6'h04; // RQ6
                next_neg_sel = 6'h08; // RQ6
            end
            3'h2: begin
                next_pos_sel = 6'h10; // RQ6
                next_neg_sel = 6'h20; // RQ6
            end
            3'h3: begin
                next_pos_sel = 6'h04; // RQ7
                next_neg_common = 1'b1; // RQ7
            end
            3'h4: begin
                next_pos_sel = 6'h08; // RQ7
                next_neg_common = 1'b1; // RQ7
            end
            3'h5: begin
                next_pos_sel = 6'h10; // RQ7
                next_neg_common = 1'b1; // RQ7
            end
            3'h6: begin
                next_pos_sel = 6'h20; // RQ7
                next_neg_common = 1'b1; // RQ7
            end
            3'h7: begin
                next_pos_common = 1'b1; // RQ8
                next_neg_common = 1'b1; // RQ8
            end
        endcase
    end

    // The reserved reference code keeps the converter path off.
    wire ref_valid = (ref_field != REF_RESERVED); // RQ17
    wire next_amp_on = amp_en_bit && gain_valid; // RQ1
    wire next_conv_on = conv_en_bit && ref_valid; // RQ10

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            amp_mode <= REG_RESET; // RQ17
            amp_channel_select <= REG_RESET; // RQ17
            amp_clock_divider <= REG_RESET; // RQ17
            converter_mode <= REG_RESET; // RQ17
            converter_clock_divider <= REG_RESET; // RQ17
        end else if (wr_stb) begin
            if (sel_amp_mode) begin
                amp_mode <= {2'b00, wdata[5:0]};
            end
            if (sel_amp_chan) begin
                amp_channel_select <= {5'b00000, wdata[2:0]};
            end
            if (sel_amp_div) begin
                amp_clock_divider <= wdata;
            end
            if (sel_conv_mode) begin
                converter_mode <= {5'b00000, wdata[2:0]};
            end
            if (sel_conv_div) begin
                converter_clock_divider <= wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rd_stb ? read_mux : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            amp_enable <= 1'b0;
            gain_code <= 3'h0;
            gain_unity <= 1'b0;
            gain_shift <= 4'h0;
            chopper_freq_field <= 2'h0;
            input_route_code <= 3'h0;
            amp_in_pos_sel <= 6'h00;
            amp_in_neg_sel <= 6'h00;
            amp_pos_to_common <= 1'b0;
            amp_neg_to_common <= 1'b0;
        end else begin
            amp_enable <= next_amp_on; // RQ1
            gain_code <= gain_field;
            gain_unity <= (gain_field == GAIN_UNITY); // RQ2
            gain_shift <= next_gain_shift; // RQ2
            chopper_freq_field <= amp_mode[CHOPPER_FREQ_LSB +: 2];
            input_route_code <= route_field;
            // Switches open while the amplifier is off, so no input is loaded.
            amp_in_pos_sel <= next_amp_on ? next_pos_sel : 6'h00;
            amp_in_neg_sel <= next_amp_on ? next_neg_sel : 6'h00;
            amp_pos_to_common <= next_amp_on && next_pos_common; // RQ8
            amp_neg_to_common <= next_amp_on && next_neg_common; // RQ7
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            converter_enable <= 1'b0;
            reference_code <= 2'h0;
            ref_internal <= 1'b0;
            inputs_supply_taps <= 1'b0;
            converter_path_on <= 1'b0;
            conversion_result <= 16'sh0000;
            result_sign_bit <= 1'b0;
        end else begin
            converter_enable <= conv_en_bit; // RQ10
            reference_code <= ref_field;
            ref_internal <= ref_field[1]; // RQ11
            inputs_supply_taps <= (ref_field == REF_BATTERY); // RQ11
            converter_path_on <= next_conv_on; // RQ11
            // The result is passed through while the converter path is on and clamped to the documented full scale.
            if (next_conv_on) begin
                if ($signed(raw_result) > FULL_SCALE_POS) begin
                    conversion_result <= FULL_SCALE_POS; // RQ12
                end else if ($signed(raw_result) < FULL_SCALE_NEG) begin
                    conversion_result <= FULL_SCALE_NEG; // RQ12
                end else begin
                    conversion_result <= $signed(raw_result); // RQ12
                end
                result_sign_bit <= raw_result[15]; // RQ12
            end
        end
    end

    clock_divider #(
        .POST_DIV(AMP_POST_DIV)
    ) amp_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(next_amp_on),
        .setting(amp_clock_divider),
        .tick(amp_clk_tick), // RQ4
        .work_clk(amp_clk)
    );

    clock_divider #(
        .POST_DIV(CONV_POST_DIV)
    ) conv_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(next_conv_on),
        .setting(converter_clock_divider),
        .tick(converter_clk_tick), // RQ13
        .work_clk(converter_clk)
    );
endmodule

// [pkg/front_end_pkg.sv]
// Package with register map, field layout, reset values and decode types of the front-end control.
// Notes on behaviour
// (RQ1) Amplifier mode bit 0 switches the gain amplifier on or off.
// (RQ2) Gain code 000/001/010/011/111 gives 16/32/64/128/1; 100-110 reserved.
// (RQ3) Software always writes chopper frequency field bits 5:4 as 10.
// (RQ4) Amplifier clock is oscillator divided by (256 minus setting), then by 8.
// (RQ5) Software should pick an amplifier clock near 4 kHz (131 at 4 MHz).
// (RQ6) Route codes 000, 001, 010 select the three differential input pairs.
// (RQ7) Codes 011 to 110 select single-ended inputs against the analog common node.
// (RQ8) Code 111 ties both amplifier inputs to the common node for offset tests.
// (RQ9) Software enables the pump regulator and programs settings before amplifier enable.
// (RQ10) Converter mode bit 0 enables or disables the 16-bit converter.
// (RQ11) Reference code 00 external, 01 reserved, 10 internal, 11 internal with supply taps.
// (RQ12) Result is two's complement, bit 15 sign, full scale magnitude 31250.
// (RQ13) Converter clock is oscillator divided by (256 minus setting), then by 2.
// (RQ14) Software uses the tabulated converter clock settings for 200, 100, 80 kHz.
// (RQ15) Software should run the converter clock at 100 kHz normally.
// (RQ16) Software waits 10 ms after pump regulator enable before using amplifier or converter.
// (RQ17) All control fields reset to zero; reserved codes leave the analog path harmless.
// (RQ18) Each divider reloads a new setting only at terminal count, avoiding short pulses.
package front_end_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] AMP_MODE_ADDR = 8'h90;
    localparam logic [7:0] AMP_CHANNEL_SELECT_ADDR = 8'h91;
    localparam logic [7:0] AMP_CLOCK_DIVIDER_ADDR = 8'h92;
    localparam logic [7:0] CONVERTER_MODE_ADDR = 8'h93;
    localparam logic [7:0] CONVERTER_CLOCK_DIVIDER_ADDR = 8'h94;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int AMP_ENABLE_BIT = 0;
    localparam int GAIN_CODE_LSB = 1;
    localparam int CHOPPER_FREQ_LSB = 4;
    localparam int CONVERTER_ENABLE_BIT = 0;
    localparam int REFERENCE_CODE_LSB = 1;
    localparam logic [7:0] DIVIDER_BASE_OFFSET = 8'h00;
    localparam int AMP_POST_DIV = 8;
    localparam int CONV_POST_DIV = 2;
    localparam logic signed [15:0] FULL_SCALE_POS = 16'sh7A12;
    localparam logic signed [15:0] FULL_SCALE_NEG = 16'sh85EE;

    typedef enum logic [2:0] {
        GAIN_16 = 3'h0,
        GAIN_32 = 3'h1,
        GAIN_64 = 3'h2,
        GAIN_128 = 3'h3,
        GAIN_UNITY = 3'h7
    } gain_code_t;

    typedef enum logic [1:0] {
        REF_EXTERNAL = 2'h0,
        REF_RESERVED = 2'h1,
        REF_INTERNAL = 2'h2,
        REF_BATTERY = 2'h3
    } reference_code_t;

    typedef enum logic [1:0] {
        DIV_IDLE = 2'b00,
        DIV_RUN = 2'b01
    } divider_state_t;
endpackage

// [verilog/clock_divider.sv]
// Reloadable clock divider producing a one-cycle enable and a square working clock.
module clock_divider
    import front_end_pkg::*;
#(
    parameter int POST_DIV = 2
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [7:0] setting,
    output logic tick,
    output logic work_clk
);
    localparam int POST_W = (POST_DIV > 2) ? $clog2(POST_DIV) : 1;
    localparam logic [POST_W-1:0] POST_LAST = POST_W'(POST_DIV - 1);

    divider_state_t state;
    logic [7:0] count;
    logic [POST_W-1:0] post;
    logic [7:0] next_count;
    logic terminal;
    logic post_last;

    // The prescaler period is 256 minus the setting; a count of all ones marks its end.
    assign terminal = (count == 8'hFF);
    assign post_last = (post == POST_LAST);
    // The register is read at the wrap itself, so a write counts from the very next period.
    assign next_count = terminal ? setting : count + 8'h01; // RQ18

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= DIV_IDLE;
            count <= DIVIDER_BASE_OFFSET;
            post <= '0;
            tick <= 1'b0;
            work_clk <= 1'b0;
        end else begin
            tick <= 1'b0;
            unique case (state)
                DIV_IDLE: begin
                    count <= setting;
                    post <= '0;
                    work_clk <= 1'b0;
                    if (run) begin
                        state <= DIV_RUN;
                    end
                end
                DIV_RUN: begin
                    // While running, a new setting is only picked up here, so no running period is cut short by a write.
                    count <= next_count; // RQ18
                    if (terminal) begin
                        post <= post_last ? '0 : post + POST_W'(1);
                        if (post_last) begin
                            tick <= 1'b1;
                        end
                        if (post_last || post == POST_W'(POST_DIV / 2 - 1)) begin
                            work_clk <= ~work_clk;
                        end
                    end
                    if (!run) begin
                        state <= DIV_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// [bench/front_end_monitor.sv]
// Checker of register decode, result limits and amplifier divider pulse spacing of the front end.
module front_end_monitor
    import front_end_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic amp_enable,
    input wire logic [2:0] gain_code,
    input wire logic [3:0] gain_shift,
    input wire logic [5:0] amp_in_pos_sel,
    input wire logic [5:0] amp_in_neg_sel,
    input wire logic amp_pos_to_common,
    input wire logic amp_neg_to_common,
    input wire logic [2:0] input_route_code,
    input wire logic amp_clk_tick,
    input wire logic converter_enable,
    input wire logic [1:0] reference_code,
    input wire logic ref_internal,
    input wire logic inputs_supply_taps,
    input wire logic converter_path_on,
    input wire logic signed [15:0] conversion_result,
    input wire logic result_sign_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_amp_write: assert property (wr_stb && addr == AMP_MODE_ADDR |-> ##2 amp_enable == ($past(wdata[0], 2)
        && (!$past(wdata[3], 2) || $past(wdata[2:1], 2) == 2'h3))) else $error("amp enable wrong after write");
    a_gain_decode: assert property (amp_enable |-> !gain_code[2] || gain_code == 3'h7) else $error("reserved gain on");
    a_gain_shift: assert property (amp_enable |-> gain_shift == (gain_code == 3'h7 ? 4'h0 : {1'b0, gain_code} + 4'h4))
        else $error("gain shift wrong");
    a_off_isolated: assert property (!amp_enable |-> {amp_in_pos_sel, amp_in_neg_sel, amp_pos_to_common,
        amp_neg_to_common} == 14'h0000) else $error("switches closed while off");
    a_short_common: assert property (amp_enable && input_route_code == 3'h7 |-> amp_pos_to_common
        && amp_neg_to_common && amp_in_pos_sel == 6'h00) else $error("input short wrong");
    a_conv_write: assert property (wr_stb && addr == CONVERTER_MODE_ADDR |-> ##2 converter_enable == $past(wdata[0], 2))
        else $error("converter enable wrong");
    a_path_gate: assert property (converter_path_on == (converter_enable && reference_code != 2'h1))
        else $error("path gate wrong");
    a_ref_decode: assert property (ref_internal == reference_code[1] && inputs_supply_taps == (reference_code == 2'h3))
        else $error("reference decode wrong");
    a_result_range: assert property (conversion_result <= FULL_SCALE_POS && conversion_result >= FULL_SCALE_NEG)
        else $error("result beyond full scale");
    a_sign_follows: assert property (result_sign_bit == conversion_result[15]) else $error("sign bit wrong");
    a_tick_spacing: assert property (amp_clk_tick |=> !amp_clk_tick [*7]) else $error("amp tick too close");
endmodule

bind amp_adc_front_end_control front_end_monitor mon_u (.clk, .sys_rst, .addr, .wdata, .wr_stb, .amp_enable,
    .gain_code, .gain_shift, .amp_in_pos_sel, .amp_in_neg_sel, .amp_pos_to_common, .amp_neg_to_common,
    .input_route_code, .amp_clk_tick, .converter_enable, .reference_code, .ref_internal, .inputs_supply_taps,
    .converter_path_on, .conversion_result, .result_sign_bit);

// [bench/amp_adc_front_end_control_tb.sv]
// Register-level testbench of the amplifier and converter front-end control.
module amp_adc_front_end_control_tb
    import front_end_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [15:0] raw_result = 16'h0000;
    logic [7:0] rdata, rv;
    logic amp_enable, gain_unity, amp_pos_to_common, amp_neg_to_common, amp_clk_tick, result_sign_bit, amp_clk;
    logic converter_enable, ref_internal, inputs_supply_taps, converter_path_on, converter_clk_tick, converter_clk;
    logic [3:0] gain_shift;
    logic [1:0] chopper_freq_field;
    logic [5:0] amp_in_pos_sel, amp_in_neg_sel;
    logic [1:0] reference_code;
    logic signed [15:0] conversion_result;
    logic [13:0] route_exp [8] = '{14'h0108, 14'h0420, 14'h1080, 14'h0401, 14'h0801, 14'h1001, 14'h2001, 14'h0003};
    logic [15:0] raw_in [4] = '{16'h7FFF, 16'h8000, 16'h1234, 16'hF000};
    logic [15:0] raw_exp [4] = '{16'h7A12, 16'h85EE, 16'h1234, 16'hF000};
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int n;

    amp_adc_front_end_control dut_u (.clk, .sys_rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .raw_result,
        .amp_enable, .gain_code(), .gain_unity, .gain_shift, .chopper_freq_field, .input_route_code(),
        .amp_in_pos_sel, .amp_in_neg_sel, .amp_pos_to_common, .amp_neg_to_common, .amp_clk, .amp_clk_tick,
        .converter_enable, .reference_code, .ref_internal, .inputs_supply_taps, .converter_path_on,
        .converter_clk, .converter_clk_tick, .conversion_result, .result_sign_bit);

    always #5 clk = ~clk;

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Returns after the decoded outputs of the write have settled.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // Measures one full tick period; the first wait skips a partial period.
    task automatic period(input bit conv, output int p);
        p = 0;
        while ((conv ? converter_clk_tick : amp_clk_tick) !== 1'b1 && p < 1100) begin
            @(negedge clk);
            p++;
        end
        p = 0;
        do begin
            @(negedge clk);
            p++;
        end while ((conv ? converter_clk_tick : amp_clk_tick) !== 1'b1 && p < 1100);
    endtask

    task automatic stop_test();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rd(AMP_MODE_ADDR, rv);
        chk(rv, 8'h00);
        rd(AMP_CHANNEL_SELECT_ADDR, rv);
        chk(rv, 8'h00);
        rd(CONVERTER_MODE_ADDR, rv);
        chk(rv, 8'h00);
        chk({amp_enable, converter_enable, conversion_result}, 18'h00000);
        // Stands in for the supply settling wait, scaled down to keep the run short.
        repeat (16) @(posedge clk);
        for (int g = 0; g < 8; g++) begin
            wr(AMP_MODE_ADDR, 8'h21 | 8'(g << 1));
            chk(amp_enable, g < 4 || g == 7);
            if (g < 4 || g == 7) chk(gain_shift, (g == 7) ? 4'h0 : 4'(g + 4));
        end
        chk(gain_unity, 1'b1);
        wr(AMP_MODE_ADDR, 8'hE7);
        rd(AMP_MODE_ADDR, rv);
        chk(rv, 8'h27);
        chk(chopper_freq_field, 2'b10);
        for (int c = 0; c < 8; c++) begin
            wr(AMP_CHANNEL_SELECT_ADDR, 8'(c));
            chk({amp_in_pos_sel, amp_in_neg_sel, amp_pos_to_common, amp_neg_to_common}, route_exp[c]);
        end
        wr(AMP_CHANNEL_SELECT_ADDR, 8'hFA);
        rd(AMP_CHANNEL_SELECT_ADDR, rv);
        chk(rv, 8'h02);
        wr(AMP_MODE_ADDR, 8'h26);
        chk({amp_enable, amp_in_pos_sel, amp_in_neg_sel, amp_pos_to_common, amp_neg_to_common}, 17'h0);
        // The setting is written while stopped so the first period is already the short one.
        wr(AMP_CLOCK_DIVIDER_ADDR, 8'hFE);
        wr(AMP_MODE_ADDR, 8'h27);
        period(1'b0, n);
        period(1'b0, n);
        chk(n, 16);
        chk(amp_clk, 1'b0);
        repeat (8) @(negedge clk);
        chk(amp_clk, 1'b1);
        wr(AMP_CLOCK_DIVIDER_ADDR, 8'hFC);
        period(1'b0, n);
        period(1'b0, n);
        chk(n, 32);
        rd(AMP_CLOCK_DIVIDER_ADDR, rv);
        chk(rv, 8'h00);
        wr(CONVERTER_CLOCK_DIVIDER_ADDR, 8'hF6);
        wr(CONVERTER_MODE_ADDR, 8'h01);
        period(1'b1, n);
        period(1'b1, n);
        chk(n, 20);
        chk(converter_clk, 1'b0);
        repeat (10) @(negedge clk);
        chk(converter_clk, 1'b1);
        wr(CONVERTER_CLOCK_DIVIDER_ADDR, 8'hEC);
        period(1'b1, n);
        period(1'b1, n);
        chk(n, 40);
        for (int r = 0; r < 4; r++) begin
            wr(CONVERTER_MODE_ADDR, 8'(r << 1) | 8'h01);
            chk({converter_enable, converter_path_on, ref_internal, inputs_supply_taps}, {1'b1, r != 1, r[1], r == 3});
        end
        rd(CONVERTER_MODE_ADDR, rv);
        chk(rv, 8'h07);
        wr(CONVERTER_MODE_ADDR, 8'h01);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            raw_result <= raw_in[i];
            repeat (3) @(negedge clk);
            chk({result_sign_bit, conversion_result}, {raw_exp[i][15], raw_exp[i]});
        end
        wr(CONVERTER_MODE_ADDR, 8'h00);
        @(posedge clk);
        raw_result <= 16'h0100;
        repeat (3) @(negedge clk);
        chk({converter_enable, conversion_result}, 17'h0F000);
        wr(AMP_CLOCK_DIVIDER_ADDR, 8'h83);
        period(1'b0, n);
        period(1'b0, n);
        chk(n, 1000);
        rd(8'h95, rv);
        chk(rv, 8'h00);
        stop_test();
    end
endmodule
